// ---- design/eem_access.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// - 256-byte data eeprom via low registers
// - program read joins 14-bit data, 13-bit address
// - one program word per read, sized range
// - byte write erases then programs
// - write duration from internal timer
// - protection blocks programmer, not the cpu
// - space select: clear data, set program
// - strobes set-only, hardware clears on completion
// - data write needs write_allow, cleared at power-up
// - warm reset during write sets write_fault_flag
// - low data and address survive a warm reset
// - write_done_flag set on completion, software clears
// - unlock register reads zero, no storage
module eem_access #(
    parameter int PROG_WORDS   = eem_pkg::PROG_DEPTH,
    parameter int WRITE_CYCLES = eem_pkg::WRITE_CYCLES
) (
    input  wire logic                        CLK,
    input  wire logic                        RESET_N,
    input  wire logic                        RST_POR,
    input  wire logic                        CODE_PROTECT,
    input  wire logic [2:0]                  SFR_SEL,
    input  wire logic                        SFR_WE,
    input  wire logic [7:0]                  SFR_WDATA,
    output logic      [7:0]                  SFR_RDATA,
    output logic                             PROG_SPACE,
    output logic                             WRITE_ALLOW,
    output logic                             WRITE_FAULT,
    output logic                             WRITE_DONE_FLAG,
    input  wire logic                        WRITE_DONE_CLR,
    output logic                             BUSY,
    input  wire logic                        PGM_REQ,
    input  wire logic                        PGM_WE,
    input  wire logic                        PGM_SPACE,
    input  wire logic [eem_pkg::PROG_AW-1:0] PGM_ADDR,
    input  wire logic [eem_pkg::PROG_DW-1:0] PGM_WDATA,
    output logic      [eem_pkg::PROG_DW-1:0] PGM_RDATA,
    output logic                             PGM_ACK,
    output logic                             PGM_DENY
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_RD_ISSUE, ST_RD_CAP, ST_ERASE, ST_PROG, ST_PGM
    } eem_state_type;
    typedef enum logic [1:0] {
        UNL_NONE, UNL_HALF, UNL_ARMED
    } eem_unlock_type;

    localparam int HALF = WRITE_CYCLES / 2;
    localparam logic [eem_pkg::TMR_W-1:0] HALF_LOAD =
        eem_pkg::TMR_W'(HALF - 1);
    localparam logic [eem_pkg::PROG_AW-1:0] PROG_MASK =
        eem_pkg::PROG_AW'(PROG_WORDS - 1);

    eem_state_type                 state_q;
    eem_unlock_type                unlock_q;
    logic                          rd_q;
    logic                          wr_q;
    logic                          psel_q;
    logic                          allow_q;
    logic                          fault_q;
    logic                          done_q;
    logic                          op_prog_q;
    logic [7:0]                    data_lo_q;
    logic [5:0]                    data_hi_q;
    logic [7:0]                    addr_lo_q;
    logic [4:0]                    addr_hi_q;
    logic [7:0]                    wr_byte_q;
    logic [7:0]                    wr_addr_q;
    logic [eem_pkg::TMR_W-1:0]     tmr_q;
    logic [7:0]                    rdata_q;
    logic                          req_s1_q;
    logic                          req_s2_q;
    logic                          req_s3_q;
    logic                          pgm_pend_q;
    logic                          pgm_space_q;
    logic                          deny_q;

    logic                          ctrl_wr;
    logic                          start_rd;
    logic                          start_wr;
    logic                          pgm_go;
    logic                          ee_en;
    logic                          ee_we;
    logic [7:0]                    ee_addr;
    logic [7:0]                    ee_wdata;
    logic [7:0]                    ee_rdata;
    logic                          fl_en;
    logic                          fl_we;
    logic [eem_pkg::PROG_AW-1:0]   fl_addr;
    logic [eem_pkg::PROG_DW-1:0]   fl_rdata;

    // ****************************************************************
    // request decode
    // ****************************************************************
    function automatic logic sfr_hit(input logic [2:0] sel);
        return SFR_WE && (SFR_SEL == sel);
    endfunction

    assign ctrl_wr  = sfr_hit(eem_pkg::SEL_CONTROL);
    assign start_rd = ctrl_wr && SFR_WDATA[eem_pkg::BIT_RD]
                      && (state_q == ST_IDLE);
    // cpu read wins over a same-cycle write request
    assign start_wr = ctrl_wr && SFR_WDATA[eem_pkg::BIT_WR] && !start_rd
                      && (state_q == ST_IDLE) && (unlock_q == UNL_ARMED)
                      && allow_q && !psel_q;
    // programmer waits behind any cpu access
    assign pgm_go   = pgm_pend_q && !CODE_PROTECT && (state_q == ST_IDLE)
                      && !start_rd && !start_wr;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            state_q <= ST_IDLE;
            tmr_q   <= '0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (start_rd)
                    begin
                        state_q <= ST_RD_ISSUE;
                    end
                    else if (start_wr)
                    begin
                        state_q <= ST_ERASE;
                        tmr_q   <= HALF_LOAD;
                    end
                    else if (pgm_go)
                    begin
                        state_q <= ST_PGM;
                    end
                end
                ST_RD_ISSUE: state_q <= ST_RD_CAP;
                ST_RD_CAP:   state_q <= ST_IDLE;
                ST_ERASE:
                begin
                    if (tmr_q == '0)
                    begin
                        state_q <= ST_PROG;
                        tmr_q   <= HALF_LOAD;
                    end
                    else
                    begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
                ST_PROG:
                begin
                    if (tmr_q == '0)
                    begin
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
                ST_PGM: state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // unlock tracking: only an unbroken key pair arms a write
    // ****************************************************************
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            unlock_q <= UNL_NONE;
        end
        else if (SFR_WE)
        begin
            if (sfr_hit(eem_pkg::SEL_UNLOCK)
                && SFR_WDATA == eem_pkg::UNLOCK_KEY1)
            begin
                unlock_q <= UNL_HALF;
            end
            else if (sfr_hit(eem_pkg::SEL_UNLOCK) && unlock_q == UNL_HALF
                     && SFR_WDATA == eem_pkg::UNLOCK_KEY2)
            begin
                unlock_q <= UNL_ARMED;
            end
            else
            begin
                unlock_q <= UNL_NONE;
            end
        end
    end

    // ****************************************************************
    // control register
    // ****************************************************************
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            rd_q   <= 1'b0;
            wr_q   <= 1'b0;
            psel_q <= 1'b0;
            if (RST_POR)
            begin
                allow_q <= 1'b0;
                fault_q <= 1'b0;
            end
            else if (wr_q)
            begin
                fault_q <= 1'b1;
            end
        end
        else
        begin
            // strobes only set by software, cleared at completion
            if (start_rd)
            begin
                rd_q <= 1'b1;
            end
            else if (state_q == ST_RD_CAP)
            begin
                rd_q <= 1'b0;
            end
            if (start_wr)
            begin
                wr_q <= 1'b1;
            end
            else if (state_q == ST_PROG && tmr_q == '0)
            begin
                wr_q <= 1'b0;
            end
            if (ctrl_wr)
            begin
                psel_q  <= SFR_WDATA[eem_pkg::BIT_PSEL];
                allow_q <= SFR_WDATA[eem_pkg::BIT_ALLOW];
                fault_q <= SFR_WDATA[eem_pkg::BIT_FAULT];
            end
        end
    end

    // set beats a same-cycle clear
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            done_q <= 1'b0;
        end
        else if (state_q == ST_PROG && tmr_q == '0)
        begin
            done_q <= 1'b1;
        end
        else if (WRITE_DONE_CLR)
        begin
            done_q <= 1'b0;
        end
    end

    // ****************************************************************
    // data and address registers
    // ****************************************************************
    // low registers hold through a warm reset so a retry is possible
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            if (RST_POR)
            begin
                data_lo_q <= eem_pkg::ZERO_BYTE;
                addr_lo_q <= eem_pkg::ZERO_BYTE;
            end
        end
        else
        begin
            if (state_q == ST_RD_CAP)
            begin
                data_lo_q <= op_prog_q ? fl_rdata[7:0] : ee_rdata;
            end
            else if (sfr_hit(eem_pkg::SEL_DATA_LOW))
            begin
                data_lo_q <= SFR_WDATA;
            end
            if (sfr_hit(eem_pkg::SEL_ADDR_LOW))
            begin
                addr_lo_q <= SFR_WDATA;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            data_hi_q <= eem_pkg::DATA_HI_RST;
            addr_hi_q <= eem_pkg::ADDR_HI_RST;
            op_prog_q <= 1'b0;
            wr_byte_q <= eem_pkg::ZERO_BYTE;
            wr_addr_q <= eem_pkg::ZERO_BYTE;
        end
        else
        begin
            if (state_q == ST_RD_CAP && op_prog_q)
            begin
                data_hi_q <= fl_rdata[13:8];
            end
            else if (sfr_hit(eem_pkg::SEL_DATA_HIGH))
            begin
                data_hi_q <= SFR_WDATA[5:0];
            end
            if (sfr_hit(eem_pkg::SEL_ADDR_HIGH))
            begin
                addr_hi_q <= SFR_WDATA[4:0];
            end
            if (start_rd)
            begin
                op_prog_q <= psel_q;
            end
            // snapshot so later sfr writes cannot disturb the write
            if (start_wr)
            begin
                wr_byte_q <= data_lo_q;
                wr_addr_q <= addr_lo_q;
            end
        end
    end

    // ****************************************************************
    // memory ports
    // ****************************************************************
    always_comb
    begin
        ee_en    = 1'b0;
        ee_we    = 1'b0;
        ee_addr  = addr_lo_q;
        ee_wdata = wr_byte_q;
        fl_en    = 1'b0;
        fl_we    = 1'b0;
        fl_addr  = {addr_hi_q, addr_lo_q} & PROG_MASK;
        if (state_q == ST_RD_ISSUE)
        begin
            ee_en = !op_prog_q;
            fl_en = op_prog_q;
        end
        else if ((state_q == ST_ERASE || state_q == ST_PROG) && tmr_q == '0)
        begin
            ee_en    = 1'b1;
            ee_we    = 1'b1;
            ee_addr  = wr_addr_q;
            // erase lands first, the new byte at the end
            ee_wdata = (state_q == ST_ERASE) ? eem_pkg::ERASED_BYTE
                                             : wr_byte_q;
        end
        else if (pgm_go)
        begin
            ee_en    = !PGM_SPACE;
            fl_en    = PGM_SPACE;
            ee_we    = PGM_WE;
            fl_we    = PGM_WE;
            ee_addr  = PGM_ADDR[7:0];
            ee_wdata = PGM_WDATA[7:0];
            fl_addr  = PGM_ADDR & PROG_MASK;
        end
    end

    eem_mem #(
        .WIDTH (8),
        .DEPTH (eem_pkg::EE_DEPTH),
        .AW    (eem_pkg::EE_AW)
    ) u_data_mem (
        .clk   (CLK),
        .en    (ee_en),
        .we    (ee_we),
        .addr  (ee_addr),
        .wdata (ee_wdata),
        .rdata (ee_rdata)
    );

    eem_mem #(
        .WIDTH (eem_pkg::PROG_DW),
        .DEPTH (PROG_WORDS),
        .AW    (eem_pkg::PROG_AW)
    ) u_prog_mem (
        .clk   (CLK),
        .en    (fl_en),
        .we    (fl_we),
        .addr  (fl_addr),
        .wdata (PGM_WDATA),
        .rdata (fl_rdata)
    );

    // ****************************************************************
    // programmer port
    // ****************************************************************
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            req_s1_q    <= 1'b0;
            req_s2_q    <= 1'b0;
            req_s3_q    <= 1'b0;
            pgm_pend_q  <= 1'b0;
            pgm_space_q <= 1'b0;
            deny_q      <= 1'b0;
        end
        else
        begin
            req_s1_q <= PGM_REQ;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            deny_q   <= 1'b0;
            if (req_s2_q && !req_s3_q && CODE_PROTECT)
            begin
                deny_q <= 1'b1;
            end
            else if (req_s2_q && !req_s3_q)
            begin
                pgm_pend_q <= 1'b1;
            end
            else if (pgm_go || CODE_PROTECT)
            begin
                pgm_pend_q <= 1'b0;
            end
            if (pgm_go)
            begin
                pgm_space_q <= PGM_SPACE;
            end
        end
    end

    // ****************************************************************
    // read-back and outputs
    // ****************************************************************
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            rdata_q <= eem_pkg::ZERO_BYTE;
        end
        else
        begin
            unique case (SFR_SEL)
                eem_pkg::SEL_CONTROL:
                    rdata_q <= {psel_q, 3'h0, fault_q, allow_q, wr_q, rd_q};
                eem_pkg::SEL_DATA_LOW:  rdata_q <= data_lo_q;
                eem_pkg::SEL_DATA_HIGH: rdata_q <= {2'h0, data_hi_q};
                eem_pkg::SEL_ADDR_LOW:  rdata_q <= addr_lo_q;
                eem_pkg::SEL_ADDR_HIGH: rdata_q <= {3'h0, addr_hi_q};
                default:
                    rdata_q <= eem_pkg::ZERO_BYTE;
            endcase
        end
    end

    assign SFR_RDATA       = rdata_q;
    assign PROG_SPACE      = psel_q;
    assign WRITE_ALLOW     = allow_q;
    assign WRITE_FAULT     = fault_q;
    assign WRITE_DONE_FLAG = done_q;
    assign BUSY            = rd_q || wr_q;
    assign PGM_ACK         = (state_q == ST_PGM);
    assign PGM_RDATA       = pgm_space_q ? fl_rdata : {6'h00, ee_rdata};
    assign PGM_DENY        = deny_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [eem_pkg::TMR_W:0] wr_len_q;
    always_ff @(posedge CLK)
    begin
        wr_len_q <= wr_q ? wr_len_q + 1'b1 : '0;
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // read strobe stands two cycles: issue, then capture
    a_rd_self_clear: assert property ($rose(rd_q) |->
        rd_q ##1 rd_q ##1 !rd_q) else $error("read strobe stuck");
    a_wr_unlocked: assert property ($rose(wr_q) |->
        $past(unlock_q) == UNL_ARMED && $past(allow_q))
        else $error("write began without unlock");
    a_wr_data_only: assert property ($rose(wr_q) |->
        !$past(psel_q)) else $error("program space write");
    a_done_on_end: assert property ($fell(wr_q) |-> done_q)
        else $error("done flag not set");
    a_unlock_zero: assert property (
        SFR_SEL == eem_pkg::SEL_UNLOCK |=> SFR_RDATA == 8'h00)
        else $error("unlock register read nonzero");
    a_protect_no_ack: assert property (
        PGM_ACK |-> !$past(CODE_PROTECT)) else $error("protected access");
    a_fault_reset: assert property (disable iff (RST_POR)
        !RESET_N && wr_q |=> fault_q) else $error("fault flag missed");
    a_low_kept: assert property (disable iff (RST_POR)
        !RESET_N |=> addr_lo_q == $past(addr_lo_q)
                     && data_lo_q == $past(data_lo_q))
        else $error("low registers lost in reset");
    a_write_length: assert property ($fell(wr_q) |->
        $past(wr_len_q) == 2 * HALF - 1) else $error("write time wrong");

    c_data_write: cover property ($fell(wr_q));
    c_prog_read: cover property (state_q == ST_RD_CAP && op_prog_q);
    c_pgm_denied: cover property (PGM_DENY);
    c_fault: cover property (disable iff (RST_POR) !RESET_N && wr_q);
endmodule // eem_access
`default_nettype wire

// ---- design/eem_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// single port memory, registered read
// ****************************************************************
module eem_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic             clk,
    input  wire logic             en,
    input  wire logic             we,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge clk)
    begin
        if (en && we)
        begin
            mem_q[addr] <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (en)
        begin
            rdata <= mem_q[addr];
        end
    end
endmodule // eem_mem
`default_nettype wire

// ---- pkg/eem_pkg.sv ----
`default_nettype none
// ****************************************************************
// ee memory access constants
// ****************************************************************
package eem_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_TIME_US = 4000;  // plain default, not a quoted figure
    localparam int WRITE_CYCLES  =
        (WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EE_DEPTH      = 256;
    localparam int EE_AW         = 8;
    localparam int PROG_DEPTH    = 8192;
    localparam int PROG_AW       = 13;
    localparam int PROG_DW       = 14;
    localparam int TMR_W         = 20;

    // register select codes on the sfr port
    localparam logic [2:0] SEL_CONTROL   = 3'h0;
    localparam logic [2:0] SEL_UNLOCK    = 3'h1;
    localparam logic [2:0] SEL_DATA_LOW  = 3'h2;
    localparam logic [2:0] SEL_DATA_HIGH = 3'h3;
    localparam logic [2:0] SEL_ADDR_LOW  = 3'h4;
    localparam logic [2:0] SEL_ADDR_HIGH = 3'h5;

    // ee_control_reg bit positions
    localparam int BIT_RD    = 0;
    localparam int BIT_WR    = 1;
    localparam int BIT_ALLOW = 2;
    localparam int BIT_FAULT = 3;
    localparam int BIT_PSEL  = 7;

    localparam logic [7:0] UNLOCK_KEY1  = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2  = 8'hAA;
    localparam logic [7:0] ERASED_BYTE  = 8'hFF;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;
    localparam logic [5:0] DATA_HI_RST  = 6'h00;
    localparam logic [4:0] ADDR_HI_RST  = 5'h00;
endpackage
`default_nettype wire

// ---- tb/test_eem_access.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// eeprom access bench
// ****************************************************************
module test_eem_access;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        por = 1'b1;
    logic        prot = 1'b0;
    logic [2:0]  sel = 3'h0;
    logic        we = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic        done_clr = 1'b0;
    logic        p_req = 1'b0;
    logic        p_space = 1'b1;
    logic        p_we = 1'b0;
    logic [12:0] p_addr = 13'h0000;
    logic [13:0] p_wd = 14'h0000;
    logic [7:0]  rdata;
    logic [13:0] p_rd;
    logic        psel, allow, fault, done, busy, ack, deny;
    logic        g_ack, g_deny;
    logic [13:0] g_data;
    logic [7:0]  v;
    int          n;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    always #5 clk = ~clk;

    eem_access #(.WRITE_CYCLES(16)) dut (.CLK(clk), .RESET_N(rst_n),
        .RST_POR(por), .CODE_PROTECT(prot), .SFR_SEL(sel), .SFR_WE(we),
        .SFR_WDATA(wdata), .SFR_RDATA(rdata), .PROG_SPACE(psel),
        .WRITE_ALLOW(allow), .WRITE_FAULT(fault), .WRITE_DONE_FLAG(done),
        .WRITE_DONE_CLR(done_clr), .BUSY(busy), .PGM_REQ(p_req),
        .PGM_WE(p_we), .PGM_SPACE(p_space), .PGM_ADDR(p_addr),
        .PGM_WDATA(p_wd), .PGM_RDATA(p_rd), .PGM_ACK(ack),
        .PGM_DENY(deny));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(negedge clk);
        sel = s;
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask

    task automatic rd(input logic [2:0] s);
        @(negedge clk);
        sel = s;
        @(negedge clk);
        v = rdata;
    endtask

    // counts cycles until the strobes drop, bounded
    task automatic idle;
        for (n = 0; n < 100 && busy !== 1'b0; n++)
            @(negedge clk);
    endtask

    task automatic unlock;
        wr(eem_pkg::SEL_UNLOCK, eem_pkg::UNLOCK_KEY1);
        wr(eem_pkg::SEL_UNLOCK, eem_pkg::UNLOCK_KEY2);
    endtask

    task automatic ee_write(input logic [7:0] a, input logic [7:0] d);
        wr(eem_pkg::SEL_ADDR_LOW, a);
        wr(eem_pkg::SEL_DATA_LOW, d);
        wr(eem_pkg::SEL_CONTROL, 8'h04);
        unlock();
        wr(eem_pkg::SEL_CONTROL, 8'h06);
    endtask

    task automatic ee_read(input logic [7:0] a, input logic [7:0] d);
        wr(eem_pkg::SEL_ADDR_LOW, a);
        wr(eem_pkg::SEL_CONTROL, 8'h05);
        idle();
        rd(eem_pkg::SEL_DATA_LOW);
        chk(v, d);
    endtask

    // programmer request held until answered, then low for 4 cycles
    task automatic pgm(input logic w, input logic [13:0] d);
        @(negedge clk);
        p_we = w;
        p_addr = 13'h1A5C;
        p_wd = d;
        p_req = 1'b1;
        for (n = 0; n < 40 && ack !== 1'b1 && deny !== 1'b1; n++)
            @(negedge clk);
        g_ack = ack;
        g_deny = deny;
        g_data = p_rd;
        p_req = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    task automatic t_reset;
        chk(psel, 1'b0);
        chk(allow, 1'b0);
        wr(eem_pkg::SEL_UNLOCK, 8'h5A);
        rd(eem_pkg::SEL_UNLOCK);
        chk(v, 8'h00);
    endtask

    task automatic t_data;
        ee_write(8'hFF, 8'hA5);
        idle();
        chk(n, 16);
        chk(done, 1'b1);
        ee_write(8'h00, 8'h3C);
        wr(eem_pkg::SEL_CONTROL, 8'h04);
        chk(busy, 1'b1);
        idle();
        @(negedge clk);
        done_clr = 1'b1;
        @(negedge clk);
        done_clr = 1'b0;
        chk(done, 1'b0);
        ee_read(8'h00, 8'h3C);
        ee_read(8'hFF, 8'hA5);
        chk(busy, 1'b0);
    endtask

    task automatic t_refuse;
        wr(eem_pkg::SEL_CONTROL, 8'h06);
        chk(busy, 1'b0);
        wr(eem_pkg::SEL_UNLOCK, eem_pkg::UNLOCK_KEY1);
        wr(eem_pkg::SEL_DATA_LOW, 8'h11);
        wr(eem_pkg::SEL_UNLOCK, eem_pkg::UNLOCK_KEY2);
        wr(eem_pkg::SEL_CONTROL, 8'h06);
        chk(busy, 1'b0);
        wr(eem_pkg::SEL_CONTROL, 8'h00);
        unlock();
        wr(eem_pkg::SEL_CONTROL, 8'h06);
        chk(busy, 1'b0);
    endtask

    task automatic t_prog;
        pgm(1'b1, 14'h2B3C);
        chk(g_ack, 1'b1);
        pgm(1'b0, 14'h0000);
        chk(g_data, 14'h2B3C);
        // programmer write into data space, read back by the cpu
        p_space = 1'b0;
        pgm(1'b1, 14'h00C3);
        p_space = 1'b1;
        chk(g_ack, 1'b1);
        ee_read(8'h5C, 8'hC3);
        wr(eem_pkg::SEL_ADDR_HIGH, 8'h1A);
        wr(eem_pkg::SEL_ADDR_LOW, 8'h5C);
        // space select acts on later strobes, so set it first
        wr(eem_pkg::SEL_CONTROL, 8'h80);
        wr(eem_pkg::SEL_CONTROL, 8'h81);
        chk(psel, 1'b1);
        idle();
        rd(eem_pkg::SEL_DATA_LOW);
        chk(v, 8'h3C);
        rd(eem_pkg::SEL_DATA_HIGH);
        chk(v, 8'h2B);
        wr(eem_pkg::SEL_CONTROL, 8'h84);
        unlock();
        wr(eem_pkg::SEL_CONTROL, 8'h86);
        chk(busy, 1'b0);
        prot = 1'b1;
        pgm(1'b0, 14'h0000);
        chk({g_ack, g_deny}, 2'b01);
        wr(eem_pkg::SEL_DATA_LOW, 8'h00);
        wr(eem_pkg::SEL_CONTROL, 8'h81);
        idle();
        rd(eem_pkg::SEL_DATA_LOW);
        chk(v, 8'h3C);
        prot = 1'b0;
        wr(eem_pkg::SEL_CONTROL, 8'h00);
    endtask

    task automatic t_fault;
        ee_write(8'h33, 8'h77);
        repeat (3) @(negedge clk);
        por = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        por = 1'b1;
        chk(fault, 1'b1);
        chk(busy, 1'b0);
        rd(eem_pkg::SEL_ADDR_LOW);
        chk(v, 8'h33);
        rd(eem_pkg::SEL_DATA_LOW);
        chk(v, 8'h77);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk({fault, allow}, 2'b00);
    endtask

    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // the tests need well under 2000 cycles
    initial
    begin
        #200000;
        n_mismatch++;
        end_sim();
    end

    initial
    begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_data();
        t_refuse();
        t_prog();
        t_fault();
        end_sim();
    end
endmodule // test_eem_access
`default_nettype wire
